// *** common/edrg_pkg.sv ***
package edrg_pkg;

    // Debug bus widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // Software register port widths
    localparam int SW_ADDR_W = 8;
    localparam int NUM_CAUSE = 5;

    // Gated windows, byte addresses in each space
    localparam logic [ADDR_W-1:0] GRP1_DBG_LO = 12'h000;
    localparam logic [ADDR_W-1:0] GRP1_DBG_HI = 12'hCFC;
    localparam logic [ADDR_W-1:0] GRP1_PMU_AD = 12'h000;
    localparam logic [ADDR_W-1:0] DOFF_A_LO = 12'h400;
    localparam logic [ADDR_W-1:0] DOFF_A_HI = 12'h4FC;
    localparam logic [ADDR_W-1:0] DOFF_B_LO = 12'h800;
    localparam logic [ADDR_W-1:0] DOFF_B_HI = 12'h8FC;
    localparam logic [ADDR_W-1:0] POFF_A_LO = 12'h000;
    localparam logic [ADDR_W-1:0] POFF_A_HI = 12'h0FC;
    localparam logic [ADDR_W-1:0] POFF_B_LO = 12'h400;
    localparam logic [ADDR_W-1:0] POFF_B_HI = 12'h47C;

    // Location of the status register in debug space
    localparam logic [ADDR_W-1:0] PRSR_ADDR = 12'h314;

    // Gating cause indices, in priority order
    localparam int CAUSE_OFF = 0;
    localparam int CAUSE_DBL = 1;
    localparam int CAUSE_OSL = 2;
    localparam int CAUSE_DOFF = 3;
    localparam int CAUSE_POFF = 4;

    // Status register bit positions
    localparam int PRSR_PU_BIT = 0;
    localparam int PRSR_SPD_BIT = 1;
    localparam int PRSR_SR_BIT = 2;
    localparam int PRSR_DBL_BIT = 3;

    // Software register offsets
    localparam logic [SW_ADDR_W-1:0] OFS_POLICY = 8'h00;
    localparam logic [SW_ADDR_W-1:0] OFS_COND = 8'h04;
    localparam logic [SW_ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [SW_ADDR_W-1:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [SW_ADDR_W-1:0] OFS_PRSR = 8'h10;

    // Policy lock bit sits above the per-cause bits
    localparam int POLICY_LOCK_BIT = 5;

    // Reset values
    localparam logic [NUM_CAUSE-1:0] POLICY_RST = 5'h1F;
    localparam logic [NUM_CAUSE-1:0] MASK_RST = 5'h00;

    // Debug space selector
    localparam logic SPACE_DBG = 1'b0;
    localparam logic SPACE_PMU = 1'b1;

endpackage

// *** src/edrg_gate.sv ***
`timescale 1ns/100ps
// Operation
// - Group one: debug 0x000-0xCFC, perfmon 0x000
// - Core off or unreachable gates group one
// - Double lock with flag set gates group one
// - OS lock flag set gates group one
// - Debug access disabled gates two mid windows
// - Debug-disable check yields to group one
// - Perfmon access disabled gates two perfmon windows
// - Perfmon check has lowest priority
// - Double lock with core powered keeps clear-after-read bits set
module edrg_gate
    import edrg_pkg::*;
#(
    parameter int AW = ADDR_W, // Debug bus address width
    parameter int DW = DATA_W // Debug bus data width
) (
    input wire logic ref_clk, // Block clock
    input wire logic rst_n, // Synchronous reset, active low
    // Debugger access side
    input wire logic dbg_req, // Access request, one cycle
    input wire logic dbg_wr, // Access is a write
    input wire logic dbg_space, // 0 debug, 1 perfmon
    input wire logic [AW-1:0] dbg_addr, // Byte address
    input wire logic dbg_reserved, // Address is reserved
    output logic dbg_resp_vld, // Answer valid, one cycle
    output logic dbg_resp_err, // Answer is an error
    output logic [DW-1:0] dbg_rdata, // Read data
    output logic dbg_fwd, // Pass access to core
    // Core condition levels
    input wire logic core_pwr_on, // Core domain powered
    input wire logic core_regs_ok, // Core registers reachable
    input wire logic double_lock_active, // Double lock in force
    input wire logic os_dlock_locked, // Double lock locked
    input wire logic os_lock_flag, // OS lock status bit
    input wire logic ext_debug_access_allowed, // Debug access on
    input wire logic ext_perfmon_access_allowed, // Perfmon on
    input wire logic evt_sticky_pd, // Core powered down event
    input wire logic evt_sticky_rst, // Core reset event
    // Software register port
    input wire logic [SW_ADDR_W-1:0] sw_addr, // Register offset
    input wire logic [DW-1:0] sw_wdata, // Write data
    input wire logic sw_wr, // Write strobe
    input wire logic sw_rd, // Read strobe
    output logic [DW-1:0] sw_rdata, // Read data, next cycle
    output logic irq // Level interrupt
);

    // Address within an inclusive window
    function automatic logic in_win(
        input logic [AW-1:0] a,
        input logic [AW-1:0] lo,
        input logic [AW-1:0] hi
    );
        in_win = (a >= lo) && (a <= hi);
    endfunction

    // Held state
    logic [NUM_CAUSE-1:0] policy_reg; // 1 error, 0 read-as-zero
    logic policy_lock_reg; // Freezes the policy
    logic [NUM_CAUSE-1:0] irq_stat_reg; // Sticky gate events
    logic [NUM_CAUSE-1:0] irq_mask_reg; // Interrupt enables
    logic sticky_pd_reg; // Clear-after-read powerdown
    logic sticky_rst_reg; // Clear-after-read reset
    logic [DW-1:0] sw_rdata_reg; // Software read data
    logic resp_vld_reg; // Debug answer valid
    logic resp_err_reg; // Debug answer error
    logic [DW-1:0] rdata_reg; // Debug read data
    logic fwd_reg; // Forward pulse

    // Decoded conditions
    logic cond_off; // Core off or unreachable
    logic cond_dbl; // Double lock holds
    logic cond_osl; // OS lock holds
    logic grp1_hit; // Address in group one
    logic doff_hit; // Address in debug mid windows
    logic poff_hit; // Address in perfmon windows
    logic [NUM_CAUSE-1:0] cause_vec; // One-hot winning cause
    logic gated; // Access is answered here
    logic gate_err; // Answer chosen for the cause
    logic prsr_hit; // Debugger reads the status reg
    logic keep_sticky; // Reads must not clear
    logic [DW-1:0] prsr_val; // Status register view
    logic [NUM_CAUSE-1:0] stat_clr; // Software clear bits
    logic sw_wr_stat; // Write to status offset

    // Status register image
    always_comb begin
        prsr_val = '0;
        prsr_val[PRSR_PU_BIT] = core_pwr_on;
        prsr_val[PRSR_SPD_BIT] = sticky_pd_reg;
        prsr_val[PRSR_SR_BIT] = sticky_rst_reg;
        prsr_val[PRSR_DBL_BIT] = os_dlock_locked;
    end

    // Group one conditions
    assign cond_off = !core_pwr_on || !core_regs_ok;
    assign cond_dbl = double_lock_active && prsr_val[PRSR_DBL_BIT];
    assign cond_osl = os_lock_flag;

    // Window decode per space
    always_comb begin
        grp1_hit = 1'b0;
        doff_hit = 1'b0;
        poff_hit = 1'b0;
        if (dbg_reserved) begin
            if (dbg_space == SPACE_DBG) begin
                // Debug space windows
                grp1_hit = in_win(dbg_addr, GRP1_DBG_LO, GRP1_DBG_HI);
                doff_hit = in_win(dbg_addr, DOFF_A_LO, DOFF_A_HI)
                    || in_win(dbg_addr, DOFF_B_LO, DOFF_B_HI);
            end else begin
                // Perfmon space windows
                grp1_hit = (dbg_addr == GRP1_PMU_AD);
                poff_hit = in_win(dbg_addr, POFF_A_LO, POFF_A_HI)
                    || in_win(dbg_addr, POFF_B_LO, POFF_B_HI);
            end
        end
    end

    // Priority pick of one cause
    always_comb begin
        cause_vec = '0;
        if (grp1_hit && cond_off) begin
            cause_vec[CAUSE_OFF] = 1'b1;
        end else if (grp1_hit && cond_dbl) begin
            cause_vec[CAUSE_DBL] = 1'b1;
        end else if (grp1_hit && cond_osl) begin
            cause_vec[CAUSE_OSL] = 1'b1;
        end else if (cond_off || cond_dbl || cond_osl) begin
            // Group one conditions mask later checks
            cause_vec = '0;
        end else if (doff_hit && !ext_debug_access_allowed) begin
            cause_vec[CAUSE_DOFF] = 1'b1;
        end else if (poff_hit && !ext_perfmon_access_allowed) begin
            cause_vec[CAUSE_POFF] = 1'b1;
        end
    end

    // Fixed answer per cause
    assign gated = |cause_vec;
    assign gate_err = |(cause_vec & policy_reg);

    // Debugger read of the status register
    assign prsr_hit = dbg_req && !dbg_wr && !gated
        && (dbg_space == SPACE_DBG) && (dbg_addr == PRSR_ADDR);
    assign keep_sticky = core_pwr_on && double_lock_active;

    // Debug answer valid and forward
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            resp_vld_reg <= 1'b0;
            fwd_reg <= 1'b0;
        end else begin
            // Gated and status reads answer here
            resp_vld_reg <= dbg_req && (gated || prsr_hit);
            // All else goes to the core
            fwd_reg <= dbg_req && !gated && !prsr_hit;
        end
    end

    // Debug answer error and data
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            resp_err_reg <= 1'b0;
            rdata_reg <= '0;
        end else if (dbg_req) begin
            // Read-as-zero drops writes, returns zero
            resp_err_reg <= gated && gate_err;
            rdata_reg <= prsr_hit ? prsr_val : '0;
        end else begin
            // Idle data held at zero
            resp_err_reg <= 1'b0;
            rdata_reg <= '0;
        end
    end

    // Clear-after-read powerdown bit
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sticky_pd_reg <= 1'b0;
        end else if (evt_sticky_pd) begin
            // New event beats a clearing read
            sticky_pd_reg <= 1'b1;
        end else if (prsr_hit && !keep_sticky) begin
            sticky_pd_reg <= 1'b0;
        end
    end

    // Clear-after-read reset bit
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sticky_rst_reg <= 1'b0;
        end else if (evt_sticky_rst) begin
            // New event beats a clearing read
            sticky_rst_reg <= 1'b1;
        end else if (prsr_hit && !keep_sticky) begin
            sticky_rst_reg <= 1'b0;
        end
    end

    // Policy register with lock
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            policy_reg <= POLICY_RST;
            policy_lock_reg <= 1'b0;
        end else if (sw_wr && (sw_addr == OFS_POLICY) && !policy_lock_reg) begin
            // Once locked, answers stay fixed until reset
            policy_reg <= sw_wdata[NUM_CAUSE-1:0];
            policy_lock_reg <= sw_wdata[POLICY_LOCK_BIT];
        end
    end

    // Interrupt mask register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_mask_reg <= MASK_RST;
        end else if (sw_wr && (sw_addr == OFS_IRQ_MASK)) begin
            irq_mask_reg <= sw_wdata[NUM_CAUSE-1:0];
        end
    end

    // Write-one-to-clear bits
    assign sw_wr_stat = sw_wr && (sw_addr == OFS_IRQ_STAT);
    assign stat_clr = sw_wr_stat ? sw_wdata[NUM_CAUSE-1:0] : '0;

    // Sticky event bits, one per cause
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CAUSE; gi++) begin : g_stat
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    irq_stat_reg[gi] <= 1'b0;
                end else if (dbg_req && cause_vec[gi]) begin
                    // Set wins over a same-cycle clear
                    irq_stat_reg[gi] <= 1'b1;
                end else if (stat_clr[gi]) begin
                    irq_stat_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Software read mux, data next cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sw_rdata_reg <= '0;
        end else if (sw_rd) begin
            sw_rdata_reg <= '0;
            case (sw_addr)
                OFS_POLICY: begin
                    sw_rdata_reg[NUM_CAUSE-1:0] <= policy_reg;
                    sw_rdata_reg[POLICY_LOCK_BIT] <= policy_lock_reg;
                end
                OFS_COND: begin
                    // Live condition levels, cause order
                    sw_rdata_reg[CAUSE_OFF] <= cond_off;
                    sw_rdata_reg[CAUSE_DBL] <= cond_dbl;
                    sw_rdata_reg[CAUSE_OSL] <= cond_osl;
                    sw_rdata_reg[CAUSE_DOFF] <= !ext_debug_access_allowed;
                    sw_rdata_reg[CAUSE_POFF] <= !ext_perfmon_access_allowed;
                end
                OFS_IRQ_STAT: begin
                    sw_rdata_reg[NUM_CAUSE-1:0] <= irq_stat_reg;
                end
                OFS_IRQ_MASK: begin
                    sw_rdata_reg[NUM_CAUSE-1:0] <= irq_mask_reg;
                end
                OFS_PRSR: begin
                    // Side-effect free view
                    sw_rdata_reg <= prsr_val;
                end
                default: begin
                    // Unmapped offsets read zero
                    sw_rdata_reg <= '0;
                end
            endcase
        end else begin
            // Data stands only one cycle
            sw_rdata_reg <= '0;
        end
    end

    // Outputs
    assign dbg_resp_vld = resp_vld_reg;
    assign dbg_resp_err = resp_err_reg;
    assign dbg_rdata = rdata_reg;
    assign dbg_fwd = fwd_reg;
    assign sw_rdata = sw_rdata_reg;
    assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule

// *** verification/edrg_gate_props.sv ***
`timescale 1ns/100ps
module edrg_gate_props
    import edrg_pkg::*;
(
    input wire logic ref_clk, // Block clock
    input wire logic rst_n, // Reset, active low
    input wire logic dbg_req, // Access request
    input wire logic dbg_space, // Space select
    input wire logic [ADDR_W-1:0] dbg_addr, // Byte address
    input wire logic dbg_reserved, // Reserved decode
    input wire logic dbg_resp_vld, // Local answer
    input wire logic dbg_resp_err, // Error answer
    input wire logic [DATA_W-1:0] dbg_rdata, // Answer data
    input wire logic dbg_fwd, // Passed to core
    input wire logic core_pwr_on, // Core powered
    input wire logic core_regs_ok, // Core reachable
    input wire logic double_lock_active, // Double lock in force
    input wire logic os_dlock_locked, // Double lock flag
    input wire logic os_lock_flag, // OS lock flag
    input wire logic ext_debug_access_allowed, // Debug access on
    input wire logic ext_perfmon_access_allowed // Perfmon access on
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Decoded causes and windows
    wire logic off_c = !core_pwr_on || !core_regs_ok;
    wire logic dbl_c = double_lock_active && os_dlock_locked;
    wire logic any_c = off_c || dbl_c || os_lock_flag;
    wire logic dsp = dbg_space == SPACE_DBG;
    wire logic stat_a = dsp && dbg_addr == PRSR_ADDR;
    wire logic rq = dbg_req && dbg_reserved;
    wire logic g1 = rq && (dsp ? (dbg_addr <= GRP1_DBG_HI && !stat_a) : dbg_addr == GRP1_PMU_AD);
    wire logic mid = rq && dsp && ((dbg_addr >= DOFF_A_LO && dbg_addr <= DOFF_A_HI) ||
        (dbg_addr >= DOFF_B_LO && dbg_addr <= DOFF_B_HI));
    wire logic pw = rq && !dsp && (dbg_addr <= POFF_A_HI || (dbg_addr >= POFF_B_LO && dbg_addr <= POFF_B_HI));
    wire logic open_c = !any_c && ext_debug_access_allowed && ext_perfmon_access_allowed;
    one_answer_a: assert property (dbg_req |=> dbg_resp_vld != dbg_fwd) else $error("bad answer count");
    no_answer_a: assert property (!dbg_req |=> !dbg_resp_vld && !dbg_fwd) else $error("stray answer");
    off_gate_a: assert property (g1 && off_c |=> dbg_resp_vld) else $error("power off not gated");
    dbl_gate_a: assert property (g1 && dbl_c |=> dbg_resp_vld) else $error("double lock not gated");
    osl_gate_a: assert property (g1 && os_lock_flag |=> dbg_resp_vld) else $error("os lock not gated");
    mid_gate_a: assert property (mid && !any_c && !ext_debug_access_allowed |=> dbg_resp_vld)
        else $error("debug window not gated");
    pmu_gate_a: assert property (pw && !any_c && ext_debug_access_allowed && !ext_perfmon_access_allowed
        |=> dbg_resp_vld) else $error("perfmon window not gated");
    pass_on_a: assert property (dbg_req && !stat_a && (!dbg_reserved || open_c) |=> dbg_fwd)
        else $error("open access not forwarded");
    raz_data_a: assert property (dbg_resp_vld && !dbg_resp_err && $past(dbg_reserved) |-> dbg_rdata == '0)
        else $error("zero answer carries data");
    cover property (g1 && off_c);
    cover property (mid && !ext_debug_access_allowed);
    cover property (dbg_resp_vld && !dbg_resp_err);
endmodule
bind edrg_gate edrg_gate_props u_props (.*);

// *** verification/edrg_dbg_model.sv ***
`timescale 1ns/100ps
module edrg_dbg_model
    import edrg_pkg::*;
(
    input wire logic ref_clk, // Block clock
    output logic dbg_req, // Access request
    output logic dbg_wr, // Write access
    output logic dbg_space, // Space select
    output logic [ADDR_W-1:0] dbg_addr, // Byte address
    output logic dbg_reserved, // Reserved decode
    input wire logic dbg_resp_vld, // Local answer
    input wire logic dbg_resp_err, // Error answer
    input wire logic [DATA_W-1:0] dbg_rdata, // Answer data
    input wire logic dbg_fwd // Passed to core
);
    // Bus idle at time zero
    initial begin
        dbg_req = 1'b0;
        dbg_wr = 1'b0;
        dbg_space = 1'b0;
        dbg_addr = '0;
        dbg_reserved = 1'b0;
    end
    // One-cycle request; answer {vld,err,fwd} and data taken in the next cycle
    task automatic access(input logic w, input logic s, input logic [ADDR_W-1:0] a, input logic r,
        output logic [2:0] ans, output logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        dbg_req <= 1'b1;
        dbg_wr <= w;
        dbg_space <= s;
        dbg_addr <= a;
        dbg_reserved <= r;
        @(posedge ref_clk);
        dbg_req <= 1'b0;
        // Released address and reserved lines show garbage, not the last value
        dbg_addr <= ~a;
        dbg_reserved <= ~r;
        @(negedge ref_clk);
        ans = {dbg_resp_vld, dbg_resp_err, dbg_fwd};
        d = dbg_rdata;
    endtask
endmodule

// *** verification/edrg_gate_tb.sv ***
`timescale 1ns/100ps
module edrg_gate_tb
    import edrg_pkg::*;
;
    localparam logic [2:0] GE = 3'b110; // Error answer
    localparam logic [2:0] RZ = 3'b100; // Zero answer
    localparam logic [2:0] FW = 3'b001; // Forwarded
    logic ref_clk = 1'b0; // Block clock
    logic rst_n = 1'b0; // Reset, active low
    logic [6:0] cnd = 7'h63; // pwr,ok,dla,dlkd,osl,dbg_ok,pmu_ok
    logic [1:0] evt = 2'b00; // Sticky events pd,rst
    logic [7:0] sw_addr = '0; // Register offset
    logic [31:0] sw_wdata = '0; // Write data
    logic sw_wr = 1'b0; // Write strobe
    logic sw_rd = 1'b0; // Read strobe
    logic [31:0] sw_rdata; // Read data
    logic irq; // Interrupt
    logic req, wr, spc, rsv, vld, err, fwd; // Debug bus
    logic [11:0] addr; // Debug address
    logic [31:0] rdat; // Debug read data
    int err_total = 0; // Mismatches
    int check_count = 0; // Comparisons
    int cyc = 0; // Cycle count
    edrg_gate DUT (.ref_clk(ref_clk), .rst_n(rst_n), .dbg_req(req), .dbg_wr(wr), .dbg_space(spc),
        .dbg_addr(addr), .dbg_reserved(rsv), .dbg_resp_vld(vld), .dbg_resp_err(err), .dbg_rdata(rdat),
        .dbg_fwd(fwd), .core_pwr_on(cnd[6]), .core_regs_ok(cnd[5]), .double_lock_active(cnd[4]),
        .os_dlock_locked(cnd[3]), .os_lock_flag(cnd[2]), .ext_debug_access_allowed(cnd[1]),
        .ext_perfmon_access_allowed(cnd[0]), .evt_sticky_pd(evt[1]), .evt_sticky_rst(evt[0]),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq));
    edrg_dbg_model DM (.ref_clk(ref_clk), .dbg_req(req), .dbg_wr(wr), .dbg_space(spc), .dbg_addr(addr),
        .dbg_reserved(rsv), .dbg_resp_vld(vld), .dbg_resp_err(err), .dbg_rdata(rdat), .dbg_fwd(fwd));
    // Clock and hang guard
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (err_total == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic set_cnd(input logic [6:0] v);
        @(posedge ref_clk);
        cnd <= v;
    endtask
    task automatic sw_w(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
    endtask
    task automatic sw_r(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge ref_clk);
        sw_rd <= 1'b0;
        @(negedge ref_clk);
        d = sw_rdata;
    endtask
    // Access and compare answer kind; data always zero here
    task automatic acc(input logic w, input logic s, input logic [11:0] a, input logic r, input logic [2:0] e);
        logic [2:0] ans;
        logic [31:0] d;
        DM.access(w, s, a, r, ans, d);
        chk({29'h0, ans}, {29'h0, e});
        chk(d, 32'h0);
    endtask
    // Eight reserved addresses, mask bit set means gated
    task automatic sweep(input logic s, input logic [11:0] ad[8], input logic [7:0] m);
        for (int i = 0; i < 8; i++) begin
            acc(1'b0, s, ad[i], 1'b1, m[i] ? GE : FW);
        end
    endtask
    task automatic t_group1();
        logic [6:0] cs[5] = '{7'h23, 7'h43, 7'h7B, 7'h67, 7'h73};
        for (int i = 0; i < 5; i++) begin
            set_cnd(cs[i]);
            acc(1'b0, SPACE_DBG, 12'hCFC, 1'b1, i < 4 ? GE : FW);
            acc(1'b1, SPACE_DBG, 12'hD00, 1'b1, FW);
            acc(1'b0, SPACE_PMU, 12'h000, 1'b1, i < 4 ? GE : FW);
            acc(1'b0, SPACE_PMU, 12'h004, 1'b1, FW);
        end
    endtask
    task automatic t_mid();
        set_cnd(7'h61);
        sweep(SPACE_DBG, '{12'h3FC, 12'h400, 12'h4FC, 12'h500, 12'h7FC, 12'h800, 12'h8FC, 12'h900}, 8'h66);
        acc(1'b0, SPACE_DBG, 12'h400, 1'b0, FW);
    endtask
    task automatic t_pmu();
        set_cnd(7'h62);
        sweep(SPACE_PMU, '{12'h000, 12'h0FC, 12'h100, 12'h3FC, 12'h400, 12'h47C, 12'h480, 12'h4FC}, 8'h33);
        acc(1'b0, SPACE_DBG, 12'h0FC, 1'b1, FW);
    endtask
    task automatic t_prio();
        logic [31:0] d;
        sw_w(OFS_POLICY, 32'h1B);
        sw_w(OFS_IRQ_STAT, 32'h1F);
        set_cnd(7'h64);
        acc(1'b0, SPACE_DBG, 12'h400, 1'b1, RZ);
        acc(1'b1, SPACE_DBG, 12'h800, 1'b1, RZ);
        acc(1'b0, SPACE_PMU, 12'h0FC, 1'b1, FW);
        sw_r(OFS_IRQ_STAT, d);
        chk(d, 32'h04);
        chk({31'h0, irq}, 32'h0);
        sw_w(OFS_IRQ_MASK, 32'h04);
        @(negedge ref_clk);
        chk({31'h0, irq}, 32'h1);
        sw_w(OFS_IRQ_STAT, 32'h04);
        @(negedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        sw_r(8'hFC, d);
        chk(d, 32'h0);
        sw_r(OFS_COND, d);
        chk(d, 32'h1C);
        sw_r(OFS_PRSR, d);
        chk(d, 32'h01);
        sw_w(OFS_POLICY, 32'h3B);
        sw_w(OFS_POLICY, 32'h1F);
        sw_r(OFS_POLICY, d);
        chk(d, 32'h3B);
    endtask
    task automatic t_sticky();
        logic [2:0] ans;
        logic [31:0] d;
        logic [6:0] cs[4] = '{7'h73, 7'h73, 7'h63, 7'h63};
        logic [31:0] ex[4] = '{32'h6, 32'h6, 32'h6, 32'h0};
        set_cnd(7'h63);
        @(posedge ref_clk);
        evt <= 2'b11;
        @(posedge ref_clk);
        evt <= 2'b00;
        for (int i = 0; i < 4; i++) begin
            set_cnd(cs[i]);
            DM.access(1'b0, SPACE_DBG, PRSR_ADDR, 1'b0, ans, d);
            chk({29'h0, ans}, {29'h0, RZ});
            chk(d & 32'h6, ex[i]);
        end
    endtask
    initial begin
        logic [31:0] d;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        chk({28'h0, vld, err, fwd, irq}, 32'h0);
        sw_r(OFS_POLICY, d);
        chk(d, 32'h1F);
        t_group1();
        t_mid();
        t_pmu();
        t_prio();
        t_sticky();
        stop_test();
    end
endmodule
